//--- logic/ddl_device.sv
// What this block does
// - 24-bit shift register samples on falling clock
// - Frame select low opens 24-bit frame
// - Serial output changes on rising clock edge
// - Serial output chains data or returns readback
// - Load pulse copies input into DAC registers
// - Load asynchronous pulse or held low synchronous
// - Reset acts asynchronously on falling edge
// - Load pulses ignored while reset low
// - Reset sets registers to zero or mid
// - Power-up level follows reset level select
// - Span select picks single or double range
//
// Local design decisions: the APB register port and the register offsets.
`default_nettype none
module ddl_device (
  // Link
  ddl_link_if.dev link,
  // Converter side
  output logic [15:0] code_a_o,
  output logic [15:0] code_b_o,
  output logic span_double_o,
  output logic [15:0] input_a_o,
  output logic [15:0] input_b_o
);
  // Shift side, falling link clock
  logic [23:0] shift_q;
  logic [4:0] cnt_q;
  // Output side, rising link clock
  logic [4:0] idx_q;
  logic chain_q;
  // Frame-end side
  logic [15:0] in_a_q;
  logic [15:0] in_b_q;
  logic [1:0] in_lvl_q;
  logic [1:0] pend_q;
  logic [23:0] rb_q;
  // Load side
  logic [15:0] dac_a_q;
  logic [15:0] dac_b_q;
  logic [1:0] dac_lvl_q;
  // Decode
  logic rst_n;
  logic [15:0] rst_code;
  logic frame_ok;
  logic [3:0] cmd;
  logic [1:0] mask;
  logic [15:0] code;
  logic is_write;
  logic is_update;
  logic is_readback;
  logic hit_a;
  logic hit_b;
  logic wr_a;
  logic wr_b;
  logic [15:0] eff_in_a;
  logic [15:0] eff_in_b;
  logic [15:0] nxt_in_a;
  logic [15:0] nxt_in_b;
  logic load_low;
  logic frame_end;
  logic frame_upd;
  logic upd_a;
  logic upd_b;
  logic rb_sel_b;
  logic [15:0] rb_code;
  logic in_word;
  logic [4:0] rb_pos;
  logic rb_bit;

  assign rst_n = link.reset_n;
  assign rst_code = link.reset_level_select ? ddl_pkg::MID_SCALE : ddl_pkg::ZERO_SCALE;
  assign cmd = shift_q[ddl_pkg::CMD_MSB:ddl_pkg::CMD_LSB];
  assign mask = shift_q[ddl_pkg::MASK_LSB+1:ddl_pkg::MASK_LSB];
  assign code = shift_q[ddl_pkg::CODE_BITS-1:0];
  assign frame_ok = (cnt_q == 5'(ddl_pkg::FRAME_BITS));

  // Command decode of the finished frame
  assign is_write = (cmd == ddl_pkg::CMD_WRITE_IN) | (cmd == ddl_pkg::CMD_WRITE_UPDATE);
  assign is_update = (cmd == ddl_pkg::CMD_UPDATE) | (cmd == ddl_pkg::CMD_WRITE_UPDATE);
  assign is_readback = (cmd == ddl_pkg::CMD_READBACK);
  assign hit_a = mask[0];
  assign hit_b = mask[1];
  assign wr_a = is_write & hit_a;
  assign wr_b = is_write & hit_b;

  // Async reset may only load constants, so a flag marks "still at reset level"
  assign eff_in_a = in_lvl_q[0] ? rst_code : in_a_q;
  assign eff_in_b = in_lvl_q[1] ? rst_code : in_b_q;
  assign nxt_in_a = wr_a ? code : eff_in_a;
  assign nxt_in_b = wr_b ? code : eff_in_b;

  assign load_low = ~link.load_outputs_n;
  assign frame_end = link.frame_n & frame_ok;
  assign frame_upd = is_update | load_low;
  assign upd_a = frame_upd & hit_a;
  assign upd_b = frame_upd & hit_b;

  // Readback word: MSB stands before the first falling edge of the frame
  assign rb_sel_b = mask[1] & ~mask[0];
  assign rb_code = rb_sel_b ? eff_in_b : eff_in_a;
  assign in_word = (idx_q < 5'(ddl_pkg::FRAME_BITS));
  assign rb_pos = 5'(ddl_pkg::FRAME_BITS - 1) - idx_q;
  assign rb_bit = in_word ? rb_q[rb_pos] : 1'b0;
  assign link.serial_out = pend_q[1] ? rb_bit : chain_q;

  assign span_double_o = link.span_select;
  assign code_a_o = dac_lvl_q[0] ? rst_code : dac_a_q;
  assign code_b_o = dac_lvl_q[1] ? rst_code : dac_b_q;
  assign input_a_o = eff_in_a;
  assign input_b_o = eff_in_b;

  // Shift and count on falling link clock while framed
  always_ff @(negedge link.sclk or posedge link.frame_n) begin
    if (link.frame_n) begin
      cnt_q <= 5'h00;
    end else if (!frame_ok) begin
      shift_q <= {shift_q[22:0], link.serial_in};
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // Readback bit position follows the falls seen so far
  always_ff @(posedge link.sclk or posedge link.frame_n) begin
    if (link.frame_n) begin
      idx_q <= 5'h00;
    end else begin
      idx_q <= cnt_q;
    end
  end

  // Chain output moves only on the rising edge, never at the fall
  always_ff @(posedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      chain_q <= 1'b0;
    end else if (!link.frame_n) begin
      chain_q <= shift_q[23];
    end
  end

  // Input registers commit on frame-select rise; reset wins asynchronously
  always_ff @(posedge link.frame_n or negedge rst_n) begin
    if (!rst_n) begin
      in_a_q <= ddl_pkg::ZERO_SCALE;
      in_b_q <= ddl_pkg::ZERO_SCALE;
      in_lvl_q <= 2'b11;
    end else if (frame_ok) begin
      if (wr_a) begin
        in_a_q <= code;
        in_lvl_q[0] <= 1'b0;
      end
      if (wr_b) begin
        in_b_q <= code;
        in_lvl_q[1] <= 1'b0;
      end
    end
  end

  // Readback request is served in the next frame
  always_ff @(posedge link.frame_n or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 2'b00;
      rb_q <= 24'h000000;
    end else if (frame_ok) begin
      pend_q <= is_readback ? 2'b10 : 2'b00;
      if (is_readback) begin
        rb_q <= {8'h00, rb_code};
      end
    end
  end

  // Load: pulse copies both channels; held low or update command copies at frame end.
  // Frame data is taken from the frame itself, since the input registers
  // change on the very same edge.
  always_ff @(negedge link.load_outputs_n or posedge link.frame_n or negedge rst_n) begin
    if (!rst_n) begin
      dac_a_q <= ddl_pkg::ZERO_SCALE;
      dac_b_q <= ddl_pkg::ZERO_SCALE;
      dac_lvl_q <= 2'b11;
    end else if (frame_end) begin
      if (upd_a) begin
        dac_a_q <= nxt_in_a;
        dac_lvl_q[0] <= 1'b0;
      end
      if (upd_b) begin
        dac_b_q <= nxt_in_b;
        dac_lvl_q[1] <= 1'b0;
      end
    end else if (load_low) begin
      dac_a_q <= eff_in_a;
      dac_b_q <= eff_in_b;
      dac_lvl_q <= 2'b00;
    end
  end
endmodule // ddl_device
`default_nettype wire

//--- logic/ddl_host.sv
`default_nettype none
module ddl_host (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Link
  ddl_link_if.host link
);
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_END} ddl_st_e;
  ddl_st_e st_q;
  logic [23:0] tx_q, rx_q;
  logic [4:0] bits_q;
  logic [1:0] half_q;
  logic [31:0] pins_q;
  logic sclk_q, frame_n_q, so_m_q, so_q;
  // Holds the device in reset while the core is in reset, giving it a power-up state
  logic rst_done_q;
  logic wr, rd, busy, tick;
  assign wr = psel_i & penable_i & pwrite_i;
  assign rd = psel_i & penable_i & ~pwrite_i;
  assign busy = (st_q != ST_IDLE);
  assign tick = (half_q == 2'(ddl_pkg::SCLK_HALF - 1));
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign prdata_o = (paddr_i == ddl_pkg::REG_TXDATA) ? {8'h00, tx_q} :
                    (paddr_i == ddl_pkg::REG_STATUS) ? {31'h0, busy} :
                    (paddr_i == ddl_pkg::REG_RXDATA) ? {8'h00, rx_q} :
                    (paddr_i == ddl_pkg::REG_PINS) ? pins_q : 32'h0;
  assign link.sclk = sclk_q;
  assign link.frame_n = frame_n_q;
  assign link.serial_in = tx_q[23];
  assign link.load_outputs_n = pins_q[ddl_pkg::PINS_LOAD_N] & ~pins_q[ddl_pkg::PINS_AUTOLOAD];
  assign link.reset_n = pins_q[ddl_pkg::PINS_RESET_N] & rst_done_q;
  assign link.reset_level_select = pins_q[ddl_pkg::PINS_RSTLVL];
  assign link.span_select = pins_q[ddl_pkg::PINS_SPAN];

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      so_m_q <= 1'b0;
      so_q <= 1'b0;
      rst_done_q <= 1'b0;
      pins_q <= ddl_pkg::PINS_RESET_VAL;
    end else begin
      rst_done_q <= 1'b1;
      so_m_q <= link.serial_out;
      so_q <= so_m_q;
      if (wr && paddr_i == ddl_pkg::REG_PINS) pins_q <= pwdata_i;
    end
  end

  // Frame engine: data set up while clock high, device samples falling edge
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= ST_IDLE;
      tx_q <= 24'h000000;
      rx_q <= 24'h000000;
      bits_q <= 5'h00;
      half_q <= 2'b00;
      sclk_q <= 1'b1;
      frame_n_q <= 1'b1;
    end else begin
      half_q <= tick ? 2'b00 : half_q + 2'b01;
      unique case (st_q)
        ST_IDLE: begin
          half_q <= 2'b00;
          if (wr && paddr_i == ddl_pkg::REG_TXDATA) tx_q <= pwdata_i[23:0];
          if (wr && paddr_i == ddl_pkg::REG_CTRL && pwdata_i[ddl_pkg::CTRL_START]) begin
            bits_q <= pwdata_i[ddl_pkg::CTRL_ABORT_AT] ? 5'h0C : 5'(ddl_pkg::FRAME_BITS);
            frame_n_q <= 1'b0;
            st_q <= ST_HIGH;
          end
        end
        ST_HIGH: if (tick) begin
          sclk_q <= 1'b0;
          rx_q <= {rx_q[22:0], so_q};
          bits_q <= bits_q - 5'h01;
          st_q <= ST_LOW;
        end
        ST_LOW: if (tick) begin
          sclk_q <= 1'b1;
          tx_q <= {tx_q[22:0], 1'b0};
          st_q <= (bits_q == 5'h00) ? ST_END : ST_HIGH;
        end
        ST_END: if (tick) begin
          frame_n_q <= 1'b1;
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // ddl_host
`default_nettype wire

//--- logic/ddl_link_if.sv
`default_nettype none
interface ddl_link_if;
  logic sclk;
  logic frame_n;
  logic serial_in;
  logic serial_out;
  logic load_outputs_n;
  logic reset_n;
  logic reset_level_select;
  logic span_select;
  modport dev (
    input sclk, frame_n, serial_in, load_outputs_n, reset_n, reset_level_select,
    input span_select,
    output serial_out
  );
  modport host (
    output sclk, frame_n, serial_in, load_outputs_n, reset_n, reset_level_select,
    output span_select,
    input serial_out
  );
endinterface
`default_nettype wire

//--- logic/ddl_pkg.sv
`default_nettype none
package ddl_pkg;
  localparam int FRAME_BITS = 24;
  localparam int CODE_BITS = 16;
  localparam int CNT_BITS = 5;
  // Frame layout chosen here: [23:20] command, [19:16] channel mask, [15:0] code
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int MASK_MSB = 19;
  localparam int MASK_LSB = 16;
  localparam logic [3:0] CMD_WRITE_IN = 4'h1;
  localparam logic [3:0] CMD_UPDATE = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
  localparam logic [3:0] CMD_READBACK = 4'h9;
  localparam logic [15:0] ZERO_SCALE = 16'h0000;
  localparam logic [15:0] MID_SCALE = 16'h8000;
  // Host divider: link clock period = 2 * SCLK_HALF core cycles
  localparam int SCLK_HALF = 3;
  localparam int HALF_BITS = 2;
  // APB register offsets of the host controller
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TXDATA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RXDATA = 8'h0C;
  localparam logic [7:0] REG_PINS = 8'h10;
  localparam int CTRL_START = 0;
  localparam int CTRL_ABORT_AT = 1;
  localparam int PINS_LOAD_N = 0;
  localparam int PINS_RESET_N = 1;
  localparam int PINS_RSTLVL = 2;
  localparam int PINS_SPAN = 3;
  localparam int PINS_AUTOLOAD = 4;
  localparam logic [31:0] PINS_RESET_VAL = 32'h0000_0003;
endpackage
`default_nettype wire

//--- sim/ddl_link_props.sv
`default_nettype none
module ddl_link_props (
  // Clocks and resets
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic reset_n,
  // Link
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic serial_out,
  input wire logic load_outputs_n,
  input wire logic reset_level_select,
  input wire logic span_select,
  // Converter side
  input wire logic span_double_o,
  input wire logic [15:0] code_a_o,
  input wire logic [15:0] code_b_o,
  input wire logic [15:0] input_a_o,
  input wire logic [15:0] input_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Link pins come from core-clock flops, so sampling there is race free
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [4:0] falls_q;
  wire [15:0] lvl = reset_level_select ? ddl_pkg::MID_SCALE : ddl_pkg::ZERO_SCALE;
  wire cpy = code_a_o == input_a_o && code_b_o == input_b_o;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) falls_q <= 5'h00;
    else if (frame_n) falls_q <= 5'h00;
    else if ($fell(sclk)) falls_q <= falls_q + 5'h01;
  end
  span_follow_a: assert property (span_double_o == span_select) else $error("span");
  sout_rise_a: assert property ($changed(serial_out) && reset_n && !frame_n |-> $rose(sclk))
    else $error("serial out edge");
  rst_level_a: assert property (!reset_n |-> code_a_o == lvl && input_b_o == lvl)
    else $error("reset level");
  rst_hold_a: assert property (!reset_n |=> $stable(code_a_o) && $stable(code_b_o))
    else $error("load during reset");
  short_drop_a: assert property ($rose(frame_n) && falls_q != 5'h18 |-> $stable(input_a_o))
    else $error("short frame kept");
  load_copy_a: assert property ($fell(load_outputs_n) && reset_n |-> ##[1:3] cpy)
    else $error("load copy");
  auto_load_a: assert property (!load_outputs_n && $rose(frame_n) && falls_q == 5'h18
    |-> ##[1:3] cpy) else $error("auto load");
  sclk_idle_a: assert property (frame_n && $past(frame_n) |-> sclk) else $error("idle");
  cover property ($rose(frame_n) && falls_q == 5'h18);
  cover property ($fell(load_outputs_n));
  cover property ($fell(reset_n));
endmodule // ddl_link_props
`default_nettype wire

//--- sim/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic nrst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, span_dbl;
  logic [15:0] code_a, code_b, in_a, in_b;
  int fails = 0, n_tests = 0;
  ddl_link_if ddl_link_if_i ();
  ddl_host ddl_host_i (.core_clk_i(core_clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(), .link(ddl_link_if_i.host));
  ddl_device ddl_device_i (.link(ddl_link_if_i.dev), .code_a_o(code_a), .code_b_o(code_b),
    .span_double_o(span_dbl), .input_a_o(in_a), .input_b_o(in_b));
  ddl_link_props ddl_link_props_i (.core_clk_i(core_clk), .nrst_i(nrst),
    .reset_n(ddl_link_if_i.reset_n), .sclk(ddl_link_if_i.sclk), .frame_n(ddl_link_if_i.frame_n),
    .serial_out(ddl_link_if_i.serial_out), .load_outputs_n(ddl_link_if_i.load_outputs_n),
    .reset_level_select(ddl_link_if_i.reset_level_select),
    .span_select(ddl_link_if_i.span_select), .span_double_o(span_dbl), .code_a_o(code_a),
    .code_b_o(code_b), .input_a_o(in_a), .input_b_o(in_b));
  always #5 core_clk = ~core_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic [3:0] c, input logic [3:0] m, input logic [15:0] v, logic s);
    apb(1'b1, ddl_pkg::REG_TXDATA, {8'h00, c, m, v});
    apb(1'b1, ddl_pkg::REG_CTRL, {30'h0, s, 1'b1});
    repeat (300) begin
      apb(1'b0, ddl_pkg::REG_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    check(32'(rd[0]), 32'h0);
  endtask
  // Pins are async on the device side, so give them a few cycles to land
  task automatic pins(input logic [31:0] v);
    apb(1'b1, ddl_pkg::REG_PINS, v);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic t_power;
    check({code_a, 15'h0, span_dbl}, 32'h0);
    pins(32'h0000_000B);
    check(32'(span_dbl), 32'h1);
    pins(ddl_pkg::PINS_RESET_VAL);
    $display("power-up done");
  endtask
  task automatic t_load;
    frame(ddl_pkg::CMD_WRITE_IN, 4'h1, 16'h1234, 1'b0);
    frame(ddl_pkg::CMD_WRITE_IN, 4'h2, 16'hBEEF, 1'b0);
    check({in_b, code_a}, 32'hBEEF_0000);
    pins(32'h0000_0002);
    pins(ddl_pkg::PINS_RESET_VAL);
    check({code_a, code_b}, 32'h1234_BEEF);
    $display("load done");
  endtask
  task automatic t_frames;
    frame(ddl_pkg::CMD_WRITE_UPDATE, 4'h3, 16'h5A5A, 1'b0);
    check({code_a, code_b}, 32'h5A5A_5A5A);
    frame(ddl_pkg::CMD_WRITE_UPDATE, 4'h3, 16'hFFFF, 1'b1);
    check({in_a, code_b}, 32'h5A5A_5A5A);
    // Second readback covers data arriving in the frame after the request
    frame(ddl_pkg::CMD_READBACK, 4'h1, 16'h0000, 1'b0);
    frame(ddl_pkg::CMD_READBACK, 4'h1, 16'h0000, 1'b0);
    apb(1'b0, ddl_pkg::REG_RXDATA, 32'h0);
    check(32'(rd[15:0]), 32'h5A5A);
    pins(32'h0000_0012);
    frame(ddl_pkg::CMD_WRITE_IN, 4'h1, 16'h0F0F, 1'b0);
    check(32'(code_a), 32'h0F0F);
    $display("frames done");
  endtask
  task automatic t_reset;
    pins(32'h0000_0007);
    pins(32'h0000_0005);
    check({code_a, in_b}, {ddl_pkg::MID_SCALE, ddl_pkg::MID_SCALE});
    pins(32'h0000_0004);
    pins(32'h0000_0005);
    check(32'(code_b), 32'(ddl_pkg::MID_SCALE));
    pins(32'h0000_0007);
    $display("reset done");
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    nrst <= 1'b0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    t_power;
    t_load;
    t_frames;
    t_reset;
    tally_and_finish;
  end
  initial begin
    #300_000;
    fails++;
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
